// >>> rtl/psh_pkg.sv
// shared constants and types of the printer strobe handshake block
package psh_pkg;

	// register byte offsets
	localparam logic [3:0] REG_DATA_OFS   = 4'h0;
	localparam logic [3:0] REG_CTRL_OFS   = 4'h4;
	localparam logic [3:0] REG_STATUS_OFS = 4'h8;

	// control word: bit 8 asserted marks load print buffer
	localparam int CTRL_LPB_BIT = 8;

	// data word bit positions, data line 9 = bit 7 ... line 16 = bit 0
	localparam int DATA_BIT10 = 6;
	localparam int DATA_BIT11 = 5;
	localparam int PRINT_B6   = 5;
	localparam int PM_DOUBLE_BIT = 0;

	// status register bit positions
	localparam int ST_DATA_REQ  = 0;
	localparam int ST_COMPLETE  = 1;
	localparam int ST_STAT_IRQ  = 2;
	localparam int ST_TIMEOUT   = 3;
	localparam int ST_MOTOR_ON  = 4;
	localparam int ST_ACK_READY = 5;
	localparam int ST_LOADED    = 6;
	localparam int ST_BAD_CHAR  = 7;

	// character codes
	localparam logic [6:0] DELETE_CODE    = 7'h7F;
	localparam logic [6:0] QUESTION_CODE  = 7'h3F;
	localparam logic [6:0] MOTOR_ON_CODE  = 7'h11;
	localparam logic [6:0] MOTOR_OFF_CODE = 7'h13;

	// data source select
	localparam logic [1:0] SRC_MOTOR   = 2'h0;
	localparam logic [1:0] SRC_PAPER   = 2'h1;
	localparam logic [1:0] SRC_INVALID = 2'h2;
	localparam logic [1:0] SRC_PRINT   = 2'h3;

	// timing
	localparam int CLK_MHZ        = 100;
	localparam int TICK_MS        = 250;
	localparam int TICK_CYCLES    = TICK_MS * 1000 * CLK_MHZ;
	localparam logic [7:0] IDLE_TICKS = 8'hF0;

	// reset values
	localparam logic [7:0] BUF_RST = 8'h00;

	typedef enum logic [2:0] {
		SEQ_IDLE   = 3'b001,
		SEQ_STROBE = 3'b010,
		SEQ_HALF   = 3'b100
	} psh_seq_type;

	typedef struct packed {
		logic        ack_s1;
		logic        ack_s2;
		logic        ack_ff;
		logic        ack_ready;
		logic        char_loaded;
		logic        data_irq;
		psh_seq_type seq;
		logic        paper_motion_first;
		logic        paper_motion_second;
		logic        lpb;
		logic        motor_on;
		logic        timeout;
		logic        op_complete;
		logic        status_irq;
		logic [7:0]  buf_data;
		logic [6:0]  pdata;
		logic [1:0]  sel;
		logic [24:0] tick_cnt;
		logic [7:0]  idle_cnt;
		logic        ph_valid;
		logic        ph_write;
		logic [3:0]  ph_addr;
		logic [31:0] rdata;
	} psh_state_type;

endpackage

// >>> rtl/psh_printer_strobe.sv
// printer strobe and acknowledge sequencer with ahb-lite register port
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

module psh_printer_strobe
	import psh_pkg::*;
#(
	parameter int TICK_COUNT = TICK_CYCLES
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// operator clear
	input  wire logic        clear_button,
	// printer link
	input  wire logic        ack_n,
	output logic             printer_strobe_n,
	output logic [6:0]       printer_data,
	output logic             source_sel_a,
	output logic             source_sel_b,
	// processor lines
	output logic             data_irq_n,
	output logic             status_irq_n,
	output logic             idle_timeout_n
);

	psh_state_type s_q;
	psh_state_type s_d;

	logic addr_go;
	logic wr_go;
	logic wr_data;
	logic wr_ctrl;
	logic instr_line;
	logic ctrl_bit8_n;
	logic buffer_reset_n;
	logic status_read_enable;
	logic strobe_ff;
	logic strobe_second_half;
	logic second_half_pulse;
	logic strobe_arm;
	logic strobe_inhibit_n;
	logic bad_char_detect_n;
	logic delete_detect_n;
	logic bit11_low_select_n;
	logic ack_rise;
	logic pm_busy;
	logic complete_set;
	logic [7:0] status_bits;
	logic [1:0] src;
	logic [6:0] char_out;

	//////////////////////////////////////////////////////////////////////////////
	// combinational decode

	always_comb begin
		addr_go = hsel && hready && htrans[1];
		wr_go   = s_q.ph_valid && s_q.ph_write;
		wr_data = wr_go && (s_q.ph_addr == REG_DATA_OFS);
		wr_ctrl = wr_go && (s_q.ph_addr == REG_CTRL_OFS);
		instr_line  = wr_ctrl;
		ctrl_bit8_n = !hwdata[CTRL_LPB_BIT];
		// lpb control word keeps the buffer cleared
		buffer_reset_n = !(instr_line && !ctrl_bit8_n);
		status_read_enable = addr_go && !hwrite && (haddr[3:0] == REG_STATUS_OFS);
		strobe_ff          = (s_q.seq == SEQ_STROBE) || (s_q.seq == SEQ_HALF);
		strobe_second_half = (s_q.seq == SEQ_HALF);
		second_half_pulse  = strobe_second_half;
		strobe_arm         = s_q.char_loaded || s_q.timeout;
		pm_busy            = s_q.paper_motion_first || s_q.paper_motion_second;
		// second paper motion strobe only when a double space is asked
		strobe_inhibit_n = !(s_q.paper_motion_second && !s_q.buf_data[PM_DOUBLE_BIT]);
		complete_set     = second_half_pulse && s_q.paper_motion_second;
		bad_char_detect_n  = s_q.buf_data[DATA_BIT10] || s_q.buf_data[DATA_BIT11];
		delete_detect_n    = (s_q.buf_data[6:0] != DELETE_CODE);
		bit11_low_select_n = !s_q.buf_data[DATA_BIT11];
		ack_rise = s_q.ack_s2 && !s_q.ack_ff;
		status_bits = '0;
		status_bits[ST_DATA_REQ]  = s_q.data_irq;
		status_bits[ST_COMPLETE]  = s_q.op_complete;
		status_bits[ST_STAT_IRQ]  = s_q.status_irq;
		status_bits[ST_TIMEOUT]   = s_q.timeout;
		status_bits[ST_MOTOR_ON]  = s_q.motor_on;
		status_bits[ST_ACK_READY] = s_q.ack_ready;
		status_bits[ST_LOADED]    = s_q.char_loaded;
		status_bits[ST_BAD_CHAR]  = !bad_char_detect_n;
		// data source for the next strobe
		if (pm_busy) begin
			src = SRC_PAPER;
		end else if (!s_q.char_loaded) begin
			src = SRC_MOTOR;
		end else if (s_q.lpb && !s_q.motor_on) begin
			src = SRC_MOTOR;
		end else if (s_q.lpb) begin
			src = SRC_PRINT;
		end else if (!bad_char_detect_n) begin
			src = SRC_INVALID;
		end else begin
			src = SRC_PRINT;
		end
		char_out = s_q.buf_data[6:0];
		char_out[PRINT_B6] = !bit11_low_select_n;
		if (!delete_detect_n) begin
			char_out = QUESTION_CODE;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_d = s_q;
		// acknowledge synchroniser and flop
		s_d.ack_s1 = ack_n;
		s_d.ack_s2 = s_q.ack_s1;
		s_d.ack_ff = s_q.ack_s2;

		// bus address phase and read data
		s_d.ph_valid = addr_go;
		s_d.ph_write = addr_go && hwrite;
		s_d.ph_addr  = addr_go ? haddr[3:0] : s_q.ph_addr;
		if (addr_go && !hwrite) begin
			if (haddr[3:0] == REG_STATUS_OFS) begin
				s_d.rdata = {24'h000000, status_bits};
			end else if (haddr[3:0] == REG_DATA_OFS) begin
				s_d.rdata = {24'h000000, s_q.buf_data};
			end else begin
				s_d.rdata = 32'h00000000;
			end
		end

		// status read clears interrupting status
		if (status_read_enable) begin
			s_d.op_complete = 1'b0;
			s_d.status_irq  = 1'b0;
		end

		// processor writes
		if (wr_data || wr_ctrl) begin
			s_d.char_loaded = 1'b1;
			s_d.data_irq    = 1'b0;
			if (buffer_reset_n) begin
				s_d.buf_data = hwdata[7:0];
			end else begin
				s_d.buf_data = BUF_RST;
			end
		end
		if (wr_ctrl) begin
			s_d.lpb = !ctrl_bit8_n;
			s_d.paper_motion_first = ctrl_bit8_n;
		end

		// strobe sequence
		case (s_q.seq)
			SEQ_IDLE: begin
				if (strobe_arm && s_q.ack_ready) begin
					s_d.seq   = SEQ_STROBE;
					s_d.sel   = src;
					if (src == SRC_MOTOR) begin
						s_d.pdata = (s_q.lpb && s_q.char_loaded) ? MOTOR_ON_CODE : MOTOR_OFF_CODE;
					end else if (src == SRC_INVALID) begin
						s_d.pdata = QUESTION_CODE;
					end else if (src == SRC_PRINT && s_q.lpb) begin
						s_d.pdata = DELETE_CODE;
					end else if (src == SRC_PRINT) begin
						s_d.pdata = char_out;
					end else begin
						s_d.pdata = s_q.buf_data[6:0];
					end
				end
			end
			SEQ_STROBE: begin
				s_d.seq = SEQ_HALF;
				// an inhibited strobe gets no acknowledge, keep ready
				if (strobe_inhibit_n) begin
					s_d.ack_ready = 1'b0;
				end
			end
			SEQ_HALF: begin
				s_d.seq = SEQ_IDLE;
			end
			default: begin
				s_d.seq = SEQ_IDLE;
			end
		endcase

		// second half pulse
		if (second_half_pulse) begin
			if (s_q.paper_motion_first) begin
				s_d.paper_motion_first  = 1'b0;
				s_d.paper_motion_second = 1'b1;
			end else if (s_q.paper_motion_second) begin
				s_d.paper_motion_second = 1'b0;
				s_d.op_complete = 1'b1;
				s_d.status_irq  = 1'b1;
				if (!(wr_data || wr_ctrl)) begin
					s_d.char_loaded = 1'b0;
				end
			end else if (s_q.char_loaded) begin
				if (!(wr_data || wr_ctrl)) begin
					s_d.char_loaded = 1'b0;
				end
				s_d.data_irq = 1'b1;
				if (s_q.lpb) begin
					s_d.motor_on = 1'b1;
					if (!wr_ctrl) begin
						s_d.lpb = 1'b0;
					end
				end
			end else begin
				s_d.timeout  = 1'b0;
				s_d.motor_on = 1'b0;
			end
		end

		// acknowledge return rearms the strobe
		if (ack_rise) begin
			s_d.ack_ready = 1'b1;
		end

		// idle timer, cleared by a control write, held while writing data or in a second half
		if (wr_ctrl || clear_button) begin
			s_d.tick_cnt = '0;
			s_d.idle_cnt = '0;
		end else if (!wr_go && !strobe_second_half && !s_q.timeout && s_q.motor_on) begin
			if (s_q.tick_cnt == 25'(TICK_COUNT - 1)) begin
				s_d.tick_cnt = '0;
				s_d.idle_cnt = s_q.idle_cnt + 8'h01;
			end else begin
				s_d.tick_cnt = s_q.tick_cnt + 25'h0000001;
			end
		end
		if (s_q.idle_cnt == IDLE_TICKS) begin
			s_d.timeout  = 1'b1;
			s_d.idle_cnt = '0;
		end

		// clear pushbutton sets ready, clears sequence, loaded, paper motion, lpb, timeout and idle timer
		if (clear_button) begin
			s_d.ack_ready = 1'b1;
			s_d.seq       = SEQ_IDLE;
			s_d.char_loaded = 1'b0;
			s_d.paper_motion_first  = 1'b0;
			s_d.paper_motion_second = 1'b0;
			s_d.lpb     = 1'b0;
			s_d.timeout = 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '{
				ack_s1: 1'b1, ack_s2: 1'b1, ack_ff: 1'b1,
				ack_ready: 1'b1,
				char_loaded: 1'b0, data_irq: 1'b0, seq: SEQ_IDLE,
				paper_motion_first: 1'b0, paper_motion_second: 1'b0,
				lpb: 1'b0, motor_on: 1'b0, timeout: 1'b0,
				op_complete: 1'b0, status_irq: 1'b0,
				buf_data: BUF_RST, pdata: 7'h00, sel: SRC_MOTOR,
				tick_cnt: 25'h0000000, idle_cnt: 8'h00,
				ph_valid: 1'b0, ph_write: 1'b0, ph_addr: 4'h0,
				rdata: 32'h00000000
			};
		end else begin
			s_q <= s_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// outputs

	assign hreadyout        = 1'b1;
	assign hresp            = 1'b0;
	assign hrdata           = s_q.rdata;
	assign printer_strobe_n = !(strobe_ff && strobe_inhibit_n);
	assign printer_data     = s_q.pdata;
	assign source_sel_a     = s_q.sel[0];
	assign source_sel_b     = s_q.sel[1];
	assign data_irq_n       = !s_q.data_irq;
	assign status_irq_n     = !s_q.status_irq;
	assign idle_timeout_n   = !s_q.timeout;

	//////////////////////////////////////////////////////////////////////////////
	// assertions

	a_strobe_needs_ready: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(strobe_ff) |-> $past(s_q.ack_ready) && $past(strobe_arm))
		else $error("strobe started without ready");

	a_write_sets_loaded: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_data || wr_ctrl) && !clear_button |=> s_q.char_loaded)
		else $error("write did not set character loaded");

	a_write_clears_irq: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_data || wr_ctrl) && !second_half_pulse |=> !s_q.data_irq)
		else $error("write did not clear data interrupt");

	a_strobe_sequence: assert property (@(posedge hclk) disable iff (!hresetn)
		s_q.seq == SEQ_STROBE && !clear_button |=> s_q.seq == SEQ_HALF ##1 s_q.seq == SEQ_IDLE)
		else $error("strobe sequence broken");

	a_strobe_drops_ready: assert property (@(posedge hclk) disable iff (!hresetn)
		s_q.seq == SEQ_STROBE && strobe_inhibit_n && !ack_rise && !clear_button
		|=> !s_q.ack_ready)
		else $error("strobe did not clear ready");

	a_pulse_sets_irq: assert property (@(posedge hclk) disable iff (!hresetn)
		second_half_pulse && s_q.char_loaded && !pm_busy && !wr_go && !clear_button
		|=> s_q.data_irq && !s_q.char_loaded)
		else $error("second half did not hand back");

	a_ack_return_ready: assert property (@(posedge hclk) disable iff (!hresetn)
		!s_q.ack_s2 ##1 s_q.ack_s2 |=> s_q.ack_ready)
		else $error("acknowledge return did not set ready");

	a_lpb_no_capture: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_ctrl && !ctrl_bit8_n |=> s_q.buf_data == BUF_RST)
		else $error("load print buffer captured data");

	a_pm_complete: assert property (@(posedge hclk) disable iff (!hresetn)
		complete_set && !clear_button |=> s_q.op_complete && s_q.status_irq)
		else $error("paper motion did not complete");

	a_idle_timeout: assert property (@(posedge hclk) disable iff (!hresetn)
		s_q.idle_cnt == IDLE_TICKS && !clear_button |=> s_q.timeout)
		else $error("idle count did not time out");

endmodule // psh_printer_strobe

`default_nettype wire

// >>> tb/printer_strobe_handshake_tb.sv
// self-checking bench of the printer strobe handshake block
`timescale 1ns/1ps
`default_nettype none

module printer_strobe_handshake_tb;
	import psh_pkg::*;
	// long enough that a full print line cannot time out, short enough to reach the timeout
	localparam int TICK = 64;
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, clear_button;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        ack_n, printer_strobe_n, source_sel_a, source_sel_b;
	logic        data_irq_n, status_irq_n, idle_timeout_n;
	logic [6:0]  printer_data;
	logic [7:0]  d;
	int          num_errors, compares, seed, n;
	time         t0;

	assign hready = hreadyout;

	psh_printer_strobe #(.TICK_COUNT(TICK)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.clear_button(clear_button), .ack_n(ack_n), .printer_strobe_n(printer_strobe_n),
		.printer_data(printer_data), .source_sel_a(source_sel_a), .source_sel_b(source_sel_b),
		.data_irq_n(data_irq_n), .status_irq_n(status_irq_n), .idle_timeout_n(idle_timeout_n));

	psh_printer_model i_prn (.hclk(hclk), .printer_strobe_n(printer_strobe_n),
		.printer_data(printer_data), .sel({source_sel_b, source_sel_a}), .ack_n(ack_n));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		foreach (i_prn.low_len[i]) check(i_prn.low_len[i], 2);
		if (num_errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// single word transfer: address phase, then data phase
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		int k;
		k = 0;
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= a;
		hsize <= 3'h2;
		do begin @(posedge hclk); k++; end while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do begin @(posedge hclk); k++; end while (hready !== 1'b1);
		rd = hrdata;
		check(hresp, 1'b0);
		check(k < 100, 1'b1);
	endtask

	task automatic want(input logic [8:0] exp);
		int k;
		k = 0;
		while (i_prn.q_got.size() == 0 && k < 3000) begin @(posedge hclk); k++; end
		if (k >= 3000) check(1'b0, 1'b1);
		else check(i_prn.q_got.pop_front(), exp);
	endtask

	task automatic wait0(ref logic s);
		int k;
		k = 0;
		while (s !== 1'b0 && k < 20000) begin @(posedge hclk); k++; end
		check(s, 1'b0);
	endtask

	function automatic logic [8:0] exp_char(input logic [7:0] v);
		if (v[6:0] == DELETE_CODE) return {SRC_PRINT, QUESTION_CODE};
		if (!v[DATA_BIT10] && !v[DATA_BIT11]) return {SRC_INVALID, QUESTION_CODE};
		return {SRC_PRINT, v[6:0]};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	initial begin
		repeat (60000) @(posedge hclk);
		num_errors++;
		summarize();
	end

	initial begin
		seed = 46451;
		num_errors = 0;
		compares = 0;
		{hresetn, hsel, hwrite, clear_button, htrans, hsize, haddr, hwdata} = '0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, REG_STATUS_OFS, 0);
		check(rd[ST_ACK_READY], 1'b1);
		check(rd[ST_LOADED], 1'b0);
		bus(1'b0, 32'hC, 0);
		check(rd, 32'h0);
		bus(1'b1, REG_CTRL_OFS, 32'h155);
		bus(1'b0, REG_DATA_OFS, 0);
		check(rd[7:0], BUF_RST);
		want({SRC_MOTOR, MOTOR_ON_CODE});
		wait0(data_irq_n);
		bus(1'b1, REG_DATA_OFS, 32'h41);
		@(posedge hclk);
		check(data_irq_n, 1'b1);
		bus(1'b0, REG_STATUS_OFS, 0);
		check(rd[ST_LOADED], 1'b1);
		check(rd[ST_ACK_READY], 1'b0);
		check(i_prn.q_got.size(), 0);
		want({SRC_PRINT, 7'h41});
		for (int i = 0; i < 14; i++) begin
			d = (i == 0) ? 8'h7F : (i == 1) ? 8'h9F : 8'($random(seed));
			wait0(data_irq_n);
			bus(1'b1, REG_DATA_OFS, {24'h0, d});
			want(exp_char(d));
		end
		bus(1'b1, REG_CTRL_OFS, 32'h100);
		want({SRC_PRINT, DELETE_CODE});
		bus(1'b1, REG_CTRL_OFS, 32'h045);
		want({SRC_PAPER, 7'h45});
		want({SRC_PAPER, 7'h45});
		wait0(status_irq_n);
		bus(1'b0, REG_STATUS_OFS, 0);
		check(rd[ST_STAT_IRQ:ST_COMPLETE], 2'h3);
		bus(1'b0, REG_STATUS_OFS, 0);
		check(rd[ST_STAT_IRQ:ST_COMPLETE], 2'h0);
		bus(1'b1, REG_CTRL_OFS, 32'h044);
		want({SRC_PAPER, 7'h44});
		repeat (2000) @(posedge hclk);
		check(i_prn.q_got.size(), 0);
		bus(1'b0, REG_STATUS_OFS, 0);
		check(rd[ST_ACK_READY], 1'b1);
		bus(1'b1, REG_CTRL_OFS, 32'h100);
		t0 = $time;
		want({SRC_PRINT, DELETE_CODE});
		wait0(idle_timeout_n);
		n = int'(($time - t0) / 10);
		check(n >= 239 * TICK && n <= 241 * TICK + 50, 1'b1);
		want({SRC_MOTOR, MOTOR_OFF_CODE});
		bus(1'b1, REG_CTRL_OFS, 32'h100);
		want({SRC_MOTOR, MOTOR_ON_CODE});
		clear_button <= 1'b1;
		@(posedge hclk);
		clear_button <= 1'b0;
		repeat (2) @(posedge hclk);
		bus(1'b0, REG_STATUS_OFS, 0);
		check(rd[ST_ACK_READY], 1'b1);
		repeat (1000) @(posedge hclk);
		summarize();
	end
endmodule // printer_strobe_handshake_tb

`default_nettype wire

// >>> tb/psh_printer_model.sv
// behavioural line printer: takes strobed characters, answers each with a timed low acknowledge
`timescale 1ns/1ps
`default_nettype none

module psh_printer_model #(
	parameter int ACK_CYCLES = 800
) (
	// clock
	input  wire logic       hclk,
	// strobe and data from the controller
	input  wire logic       printer_strobe_n,
	input  wire logic [6:0] printer_data,
	input  wire logic [1:0] sel,
	// acknowledge back
	output logic            ack_n
);
	logic [8:0] q_got[$];
	int         low_len[$];
	int         run;
	event       released;

	initial begin
		run = 0;
	end

	// one entry per strobe, plus the length of each low period
	always @(posedge hclk) begin
		if (printer_strobe_n === 1'b0) begin
			if (run == 0)
				q_got.push_back({sel, printer_data});
			run = run + 1;
		end else if (run != 0) begin
			low_len.push_back(run);
			run = 0;
			-> released;
		end
	end

	// low acknowledge for 8 us after each strobe release
	initial begin
		ack_n = 1'b1;
		forever begin
			@(released);
			ack_n <= 1'b0;
			repeat (ACK_CYCLES) @(posedge hclk);
			ack_n <= 1'b1;
		end
	end
endmodule // psh_printer_model

`default_nettype wire
